// ### hdl/itsc_ctrl.sv
// itsc_ctrl: interrupt status, vectoring, traps, trap pin and standby.
// assumes core strobes are on I_CLK; ext and trap pins are asynchronous.
`timescale 1ns/1ps
module itsc_ctrl (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  input  wire itsc_pkg::itsc_src_t I_PERIPH_EVENT,
  input  wire logic              I_EXT0_PIN,
  input  wire logic              I_EXT1_PIN,
  input  wire logic              I_SW_IRQ,
  input  wire itsc_pkg::itsc_src_t I_IRQ_ENABLE,
  input  wire logic              I_STATUS_WR,
  input  wire itsc_pkg::itsc_src_t I_STATUS_WDATA,
  input  wire logic              I_HOST_IN_RD,
  input  wire logic              I_HOST_OUT_WR,
  input  wire logic              I_SER_IN_RD,
  input  wire logic              I_SER_OUT_WR,
  input  wire logic              I_SER2_IN_RD,
  input  wire logic              I_SER2_OUT_WR,
  input  wire logic              I_DBG_RD,
  input  wire logic              I_INSN_DONE,
  input  wire logic              I_INSN_INTERRUPTIBLE,
  input  wire logic              I_INSN_TWO_CYCLE,
  input  wire itsc_pkg::itsc_addr_t I_PC_NEXT,
  input  wire itsc_pkg::itsc_addr_t I_PC_AFTER_NEXT,
  input  wire logic              I_IRETURN,
  input  wire logic              I_BREAKPOINT,
  input  wire logic              I_DBG_TRAP_REQ,
  input  wire logic              I_TRAP_OUT_MODE,
  input  wire logic              I_TRAP_DEBUG_MODE,
  input  wire logic              I_TRAP_PIN,
  input  wire logic              I_SLEEP_SET,
  input  wire logic              I_XFER_BUSY,
  output logic                   O_TRAP_OUT,
  output logic                   O_TRAP_OE,
  output logic                   O_SERVICE_ACK,
  output itsc_pkg::itsc_code_t   O_SOURCE_CODE,
  output itsc_pkg::itsc_src_t    O_IRQ_STATUS,
  output logic                   O_BRANCH,
  output itsc_pkg::itsc_vec_t    O_BRANCH_ADDR,
  output itsc_pkg::itsc_addr_t   O_IRQ_RETURN,
  output logic                   O_ROM_LOW_MAP_FORCE,
  output logic                   O_SLEEP_BIT,
  output logic                   O_STANDBY
);
  import itsc_pkg::*;

  initial begin
    if (SYNC_STAGES + 2 != TRAP_LAT_CYC) begin
      $error("itsc_ctrl: trap latency does not match the pin pipeline");
    end
  end

  // pin synchronisers: stage 1 feeds stage 2 only
  logic [SYNC_STAGES-1:0] ext0_sync_reg;
  logic [SYNC_STAGES-1:0] ext1_sync_reg;
  logic [SYNC_STAGES-1:0] trap_sync_reg;
  logic                   ext0_prev_reg;
  logic                   ext1_prev_reg;
  logic                   trap_prev_reg;
  logic                   ext0_rise;
  logic                   ext1_rise;
  logic                   trap_rise;

  itsc_src_t              status_reg;
  itsc_src_t              status_next;
  itsc_src_t              set_vec;
  itsc_src_t              clr_vec;
  logic [3:0]             ser_pend_reg;
  logic [3:0]             ser_apply;

  logic                   isr_active_reg;
  logic [IDX_W-1:0]       isr_idx_reg;
  logic                   utrap_active_reg;
  logic                   dtrap_active_reg;
  logic                   utrap_pend_reg;
  logic                   dtrap_pend_reg;
  logic                   trap_dir_reg;
  logic                   trap_drive_reg;
  logic                   trap_busy;
  logic                   take_trap;
  logic                   take_user;
  logic                   take_vec;
  logic                   ret_trap;
  logic                   ret_isr;

  logic                   ack_reg;
  itsc_code_t             code_reg;
  logic                   branch_reg;
  itsc_vec_t              branch_addr_reg;
  itsc_addr_t             irq_ret_reg;

  logic                   sleep_reg;
  logic                   armed_reg;
  logic                   standby_reg;
  logic                   wake;

  itsc_sel_if sel_bus ();

  itsc_prio #(.N(NSRC)) u_prio (
    .sel (sel_bus)
  );

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ext0_sync_reg <= '0;
      ext1_sync_reg <= '0;
      trap_sync_reg <= '0;
      ext0_prev_reg <= 1'b0;
      ext1_prev_reg <= 1'b0;
      trap_prev_reg <= 1'b0;
    end else begin
      ext0_sync_reg <= {ext0_sync_reg[SYNC_STAGES-2:0], I_EXT0_PIN};
      ext1_sync_reg <= {ext1_sync_reg[SYNC_STAGES-2:0], I_EXT1_PIN};
      trap_sync_reg <= {trap_sync_reg[SYNC_STAGES-2:0], I_TRAP_PIN};
      ext0_prev_reg <= ext0_sync_reg[SYNC_STAGES-1];
      ext1_prev_reg <= ext1_sync_reg[SYNC_STAGES-1];
      trap_prev_reg <= trap_sync_reg[SYNC_STAGES-1];
    end
  end

  assign ext0_rise = ext0_sync_reg[SYNC_STAGES-1] & ~ext0_prev_reg;
  assign ext1_rise = ext1_sync_reg[SYNC_STAGES-1] & ~ext1_prev_reg;
  // pin forces trap
  // our own drive is not a request while the pin is an output
  assign trap_rise = trap_sync_reg[SYNC_STAGES-1] & ~trap_prev_reg
                   & ~trap_dir_reg;

  always_comb begin
    set_vec = I_PERIPH_EVENT;
    set_vec[SRC_EXT0] = I_PERIPH_EVENT[SRC_EXT0] | ext0_rise;
    set_vec[SRC_EXT1] = I_PERIPH_EVENT[SRC_EXT1] | ext1_rise;
    set_vec[SRC_SW] = I_PERIPH_EVENT[SRC_SW] | I_SW_IRQ;
  end

  // delayed serial clear
  // the accessing instruction's own completion does not count
  assign ser_apply = ser_pend_reg & {4{I_INSN_DONE}};

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ser_pend_reg <= 4'h0;
    end else begin
      ser_pend_reg <= (ser_pend_reg & ~ser_apply)
                    | {I_SER_OUT_WR, I_SER_IN_RD,
                       I_SER2_OUT_WR, I_SER2_IN_RD};
    end
  end

  always_comb begin
    clr_vec = '0;
    if (I_STATUS_WR) begin
      clr_vec = I_STATUS_WDATA & W1C_MASK;
    end
    clr_vec[SRC_HIN] = I_HOST_IN_RD;
    clr_vec[SRC_HOUT] = I_HOST_OUT_WR;
    clr_vec[SRC_DBG] = I_DBG_RD;
    clr_vec[SRC_S2IN] = ser_apply[0];
    clr_vec[SRC_S2OUT] = ser_apply[1];
    clr_vec[SRC_SIN] = ser_apply[2];
    clr_vec[SRC_SOUT] = ser_apply[3];
    if (ret_isr && W1C_MASK[isr_idx_reg]) begin
      clr_vec[isr_idx_reg] = 1'b1;
    end
    // software request is consumed when it is vectored
    if (take_vec && sel_bus.idx == IDX_W'(SRC_SW)) begin
      clr_vec[SRC_SW] = 1'b1;
    end
    // a new event in the clearing cycle survives
    status_next = (status_reg & ~clr_vec) | set_vec;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  assign sel_bus.req = status_reg & (I_IRQ_ENABLE | UNMASKABLE);

  assign trap_busy = utrap_active_reg | dtrap_active_reg;
  assign take_trap = (utrap_pend_reg | dtrap_pend_reg) & ~trap_busy
                   & (I_INSN_DONE | standby_reg);
  assign take_user = take_trap & utrap_pend_reg;
  assign take_vec = sel_bus.valid & I_INSN_DONE & I_INSN_INTERRUPTIBLE
                  & ~isr_active_reg & ~trap_busy & ~standby_reg
                  & ~utrap_pend_reg & ~dtrap_pend_reg;
  assign ret_trap = I_IRETURN & trap_busy;
  assign ret_isr = I_IRETURN & ~trap_busy & isr_active_reg;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      utrap_pend_reg <= 1'b0;
      dtrap_pend_reg <= 1'b0;
    end else if (take_trap) begin
      utrap_pend_reg <= 1'b0;
      dtrap_pend_reg <= 1'b0;
    end else if (!trap_busy) begin
      if (trap_rise && !I_TRAP_DEBUG_MODE) begin
        utrap_pend_reg <= 1'b1;
      end
      if ((trap_rise && I_TRAP_DEBUG_MODE) || I_BREAKPOINT
          || I_DBG_TRAP_REQ) begin
        dtrap_pend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      utrap_active_reg <= 1'b0;
      dtrap_active_reg <= 1'b0;
    end else if (take_trap) begin
      utrap_active_reg <= take_user;
      dtrap_active_reg <= ~take_user;
    end else if (ret_trap) begin
      utrap_active_reg <= 1'b0;
      dtrap_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trap_dir_reg <= 1'b0;
      trap_drive_reg <= 1'b0;
    end else begin
      trap_dir_reg <= I_TRAP_OUT_MODE;
      if (I_BREAKPOINT && trap_dir_reg) begin
        trap_drive_reg <= 1'b1;
      end else if (ret_trap || !trap_dir_reg) begin
        trap_drive_reg <= 1'b0;
      end
    end
  end

  assign O_TRAP_OE = trap_dir_reg;
  assign O_TRAP_OUT = trap_drive_reg;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      isr_active_reg <= 1'b0;
      isr_idx_reg <= '0;
    end else if (take_vec) begin
      isr_active_reg <= 1'b1;
      isr_idx_reg <= sel_bus.idx;
    end else if (ret_isr) begin
      isr_active_reg <= 1'b0;
    end
  end

  // pin to branch in four edges
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      branch_reg <= 1'b0;
      branch_addr_reg <= '0;
    end else begin
      branch_reg <= take_trap | take_vec;
      if (take_trap) begin
        branch_addr_reg <= take_user ? VEC_UTRAP : VEC_DTRAP;
      end else if (take_vec) begin
        branch_addr_reg <= SRC_VECTOR[sel_bus.idx];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ack_reg <= 1'b0;
      code_reg <= CODE_NONE;
    end else if (take_trap && take_user) begin
      ack_reg <= 1'b1;
      code_reg <= CODE_UTRAP;
    end else if (take_vec) begin
      ack_reg <= 1'b1;
      code_reg <= SRC_CODE[sel_bus.idx];
    end else if (I_IRETURN && utrap_active_reg) begin
      ack_reg <= isr_active_reg;
      code_reg <= isr_active_reg ? SRC_CODE[isr_idx_reg] : CODE_NONE;
    end else if (ret_isr) begin
      ack_reg <= 1'b0;
      code_reg <= CODE_NONE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_ret_reg <= ADDR_RST;
    end else if (take_trap || take_vec) begin
      irq_ret_reg <= I_PC_NEXT;
    end else if (I_INSN_DONE && !isr_active_reg && !trap_busy) begin
      irq_ret_reg <= I_INSN_TWO_CYCLE ? I_PC_NEXT : I_PC_AFTER_NEXT;
    end
  end

  // first interrupt wakes
  // a trap also ends standby, else its handler could never run
  assign wake = standby_reg & ((|set_vec) | take_trap);

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sleep_reg <= 1'b0;
      armed_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else if (wake) begin
      sleep_reg <= 1'b0;
      armed_reg <= 1'b0;
      standby_reg <= 1'b0;
    end else if (I_SLEEP_SET) begin
      sleep_reg <= 1'b1;
      armed_reg <= 1'b0;
    end else if (sleep_reg && !standby_reg) begin
      if (I_INSN_DONE) begin
        armed_reg <= 1'b1;
      end
      if (armed_reg && !I_XFER_BUSY) begin
        standby_reg <= 1'b1;
      end
    end
  end

  assign O_ROM_LOW_MAP_FORCE = dtrap_active_reg;

  assign O_SERVICE_ACK = ack_reg;
  assign O_SOURCE_CODE = code_reg;
  assign O_IRQ_STATUS = status_reg;
  assign O_BRANCH = branch_reg;
  assign O_BRANCH_ADDR = branch_addr_reg;
  assign O_IRQ_RETURN = irq_ret_reg;
  assign O_SLEEP_BIT = sleep_reg;
  assign O_STANDBY = standby_reg;

endmodule

// ### hdl/itsc_pkg.sv
// itsc_pkg: constants for the interrupt, trap and standby controller.
// assumes sources are numbered in ascending order of service priority.
package itsc_pkg;

  localparam int NSRC        = 13;
  localparam int IDX_W       = 4;
  localparam int ADDR_W      = 16;
  localparam int VEC_W       = 7;
  localparam int CODE_W      = 4;

  typedef logic [NSRC-1:0]   itsc_src_t;
  typedef logic [CODE_W-1:0] itsc_code_t;
  typedef logic [VEC_W-1:0]  itsc_vec_t;
  typedef logic [ADDR_W-1:0] itsc_addr_t;

  // source index, lowest priority first
  localparam int SRC_SW      = 0;
  localparam int SRC_EXT0    = 1;
  localparam int SRC_DBG     = 2;
  localparam int SRC_EXT1    = 3;
  localparam int SRC_TIMER   = 4;
  localparam int SRC_S2IN    = 5;
  localparam int SRC_S2OUT   = 6;
  localparam int SRC_CPRDY   = 7;
  localparam int SRC_CPOVF   = 8;
  localparam int SRC_SIN     = 9;
  localparam int SRC_SOUT    = 10;
  localparam int SRC_HIN     = 11;
  localparam int SRC_HOUT    = 12;

  // entry 0 is the rightmost element
  localparam logic [NSRC-1:0][CODE_W-1:0] SRC_CODE = {
    4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'he,
    4'hd, 4'hc, 4'h9, 4'h8, 4'h2, 4'h1};
  localparam logic [NSRC-1:0][VEC_W-1:0] SRC_VECTOR = {
    7'h38, 7'h34, 7'h30, 7'h2c, 7'h24, 7'h20, 7'h18,
    7'h14, 7'h10, 7'h04, 7'h42, 7'h01, 7'h02};

  localparam itsc_code_t CODE_NONE   = 4'h0;
  localparam itsc_code_t CODE_UTRAP  = 4'h7;
  localparam itsc_vec_t  VEC_UTRAP   = 7'h46;
  localparam itsc_vec_t  VEC_DTRAP   = 7'h03;

  // ext0, ext1, timer, coproc ready, coproc overflow
  localparam itsc_src_t  W1C_MASK    = 13'h019a;
  localparam itsc_src_t  UNMASKABLE  = 13'h0001;
  localparam itsc_src_t  STATUS_RST  = 13'h0000;
  localparam itsc_addr_t ADDR_RST    = 16'h0000;

  localparam int SYNC_STAGES = 2;
  localparam int TRAP_LAT_CYC = 4;

endpackage

// ### hdl/itsc_sel_if.sv
// itsc_sel_if: pending sources to the priority selector and its answer.
// assumes one clock domain; the selector is purely combinational.
`timescale 1ns/1ps
interface itsc_sel_if;
  import itsc_pkg::*;
  itsc_src_t        req;
  logic             valid;
  logic [IDX_W-1:0] idx;
  modport arb (input req, output valid, output idx);
  modport ctl (output req, input valid, input idx);
endinterface

// ### hdl/itsc_prio.sv
// itsc_prio: picks the highest-index pending source.
// assumes req already holds status gated by the enables.
`timescale 1ns/1ps
module itsc_prio #(
  parameter int N = itsc_pkg::NSRC
) (
  itsc_sel_if.arb sel
);
  import itsc_pkg::*;

  logic [N:0]   above;
  logic [N-1:0] grant;

  initial begin
    if (N < 1 || N > (1 << IDX_W)) begin
      $error("itsc_prio: source count out of range");
    end
  end

  assign above[N] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chain
      assign above[g] = above[g+1] | sel.req[g];
      assign grant[g] = sel.req[g] & ~above[g+1];
    end
  endgenerate

  always_comb begin
    sel.idx = '0;
    for (int i = 0; i < N; i++) begin
      if (grant[i]) begin
        sel.idx = IDX_W'(i);
      end
    end
  end

  assign sel.valid = above[0];

endmodule

// ### dv/itsc_ctrl_sva.sv
// itsc_ctrl_sva: port-level assertions for the controller.
// assumes it is bound to itsc_ctrl, one clock, active-low reset.
`timescale 1ns/1ps
module itsc_ctrl_sva
  import itsc_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_RST_B,
  input wire itsc_src_t  I_PERIPH_EVENT,
  input wire logic       I_STATUS_WR,
  input wire itsc_src_t  I_STATUS_WDATA,
  input wire logic       I_HOST_IN_RD,
  input wire logic       I_SER_OUT_WR,
  input wire logic       I_DBG_RD,
  input wire logic       I_INSN_DONE,
  input wire logic       I_INSN_INTERRUPTIBLE,
  input wire itsc_addr_t I_PC_NEXT,
  input wire logic       I_IRETURN,
  input wire logic       I_XFER_BUSY,
  input wire logic       O_TRAP_OE,
  input wire logic       O_SERVICE_ACK,
  input wire itsc_code_t O_SOURCE_CODE,
  input wire itsc_src_t  O_IRQ_STATUS,
  input wire logic       O_BRANCH,
  input wire itsc_vec_t  O_BRANCH_ADDR,
  input wire itsc_addr_t O_IRQ_RETURN,
  input wire logic       O_ROM_LOW_MAP_FORCE,
  input wire logic       O_SLEEP_BIT,
  input wire logic       O_STANDBY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  a_reset_idle: assert property ($rose(I_RST_B) |->
    !O_TRAP_OE && !O_SERVICE_ACK && O_IRQ_STATUS == '0)
    else $error("outputs not idle after reset");
  a_ack_on_entry: assert property (O_BRANCH &&
    O_BRANCH_ADDR != VEC_DTRAP |-> O_SERVICE_ACK)
    else $error("ack low at service entry");
  // user trap returns are left out: they fall back to an open service
  a_ack_drop_ret: assert property (I_IRETURN && O_SERVICE_ACK &&
    !O_ROM_LOW_MAP_FORCE && O_SOURCE_CODE != CODE_UTRAP
    |=> !O_SERVICE_ACK && O_SOURCE_CODE == CODE_NONE)
    else $error("ack or code kept after return");
  a_utrap_code: assert property (O_BRANCH &&
    O_BRANCH_ADDR == VEC_UTRAP |-> O_SOURCE_CODE == CODE_UTRAP)
    else $error("wrong code for user trap");
  a_dtrap_quiet: assert property (O_BRANCH &&
    O_BRANCH_ADDR == VEC_DTRAP |-> $stable(O_SERVICE_ACK) &&
    $stable(O_SOURCE_CODE) && O_ROM_LOW_MAP_FORCE)
    else $error("debug trap touched ack, code or map");
  a_host_in_clr: assert property (I_HOST_IN_RD &&
    !I_PERIPH_EVENT[SRC_HIN] |=> !O_IRQ_STATUS[SRC_HIN])
    else $error("host input flag not cleared");
  a_ser_late: assert property (I_SER_OUT_WR &&
    O_IRQ_STATUS[SRC_SOUT] |=> O_IRQ_STATUS[SRC_SOUT])
    else $error("serial flag cleared too early");
  a_dbg_clr: assert property (I_DBG_RD &&
    !I_PERIPH_EVENT[SRC_DBG] |=> !O_IRQ_STATUS[SRC_DBG])
    else $error("debug port flag not cleared");
  a_w1c_timer: assert property (I_STATUS_WR &&
    I_STATUS_WDATA[SRC_TIMER] && !I_PERIPH_EVENT[SRC_TIMER]
    |=> !O_IRQ_STATUS[SRC_TIMER])
    else $error("timer flag not cleared by write");
  a_ret_addr: assert property (O_BRANCH |->
    O_IRQ_RETURN == $past(I_PC_NEXT))
    else $error("return address not captured");
  a_vec_at_done: assert property (O_BRANCH &&
    O_BRANCH_ADDR != VEC_UTRAP && O_BRANCH_ADDR != VEC_DTRAP
    |-> $past(I_INSN_DONE) && $past(I_INSN_INTERRUPTIBLE))
    else $error("vectored without interruptible completion");
  a_sleep_level: assert property (O_STANDBY |-> O_SLEEP_BIT)
    else $error("standby without sleep bit");
  a_busy_hold: assert property (!O_STANDBY && I_XFER_BUSY
    |=> !O_STANDBY)
    else $error("standby entered during a transfer");
  a_wake: assert property (O_STANDBY && |I_PERIPH_EVENT
    |=> !O_STANDBY && !O_SLEEP_BIT)
    else $error("no wake on event");

  c_utrap: cover property (O_BRANCH && O_BRANCH_ADDR == VEC_UTRAP);
  c_dtrap: cover property (O_BRANCH && O_BRANCH_ADDR == VEC_DTRAP);
  c_standby: cover property ($rose(O_STANDBY));
endmodule

bind itsc_ctrl itsc_ctrl_sva u_sva (.I_CLK, .I_RST_B, .I_PERIPH_EVENT,
  .I_STATUS_WR, .I_STATUS_WDATA, .I_HOST_IN_RD, .I_SER_OUT_WR, .I_DBG_RD,
  .I_INSN_DONE, .I_INSN_INTERRUPTIBLE, .I_PC_NEXT, .I_IRETURN,
  .I_XFER_BUSY, .O_TRAP_OE, .O_SERVICE_ACK, .O_SOURCE_CODE,
  .O_IRQ_STATUS, .O_BRANCH, .O_BRANCH_ADDR, .O_IRQ_RETURN,
  .O_ROM_LOW_MAP_FORCE, .O_SLEEP_BIT, .O_STANDBY);

// ### dv/itsc_core_model.sv
// itsc_core_model: instruction sequencer standing in for the core.
// assumes the bench picks pace and interruptibility; branches reload pc.
`timescale 1ns/1ps
module itsc_core_model
  import itsc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_slow,
  input  wire logic       i_intr_ok,
  input  wire logic       i_branch,
  input  wire itsc_vec_t  i_branch_addr,
  input  wire logic       i_standby,
  output logic            o_done,
  output logic            o_intr,
  output logic            o_two,
  output itsc_addr_t      o_pc_next,
  output itsc_addr_t      o_pc_after
);
  logic [2:0] cnt_reg;
  itsc_addr_t pc_reg;

  // wait-states stretch each instruction; standby holds the count at zero and stops completions
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 3'h0;
    end else if (i_standby || o_done) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  // at or past the limit, so a drop of i_slow mid-count cannot wrap
  assign o_done = !i_standby && cnt_reg >= (i_slow ? 3'h4 : 3'h1);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_reg <= 16'h0000;
    end else if (i_branch) begin
      pc_reg <= {9'h000, i_branch_addr};
    end else if (o_done) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end
  // odd addresses stand for two-cycle instructions
  assign o_two      = pc_reg[0];
  assign o_intr     = i_intr_ok;
  assign o_pc_next  = pc_reg + 16'h0001;
  assign o_pc_after = pc_reg + 16'h0002;
endmodule

// ### dv/test_interrupt_trap_sleep_control.sv
// test_interrupt_trap_sleep_control: self-checking bench for itsc_ctrl.
// assumes itsc_core_model plays the core and the bench the peripherals.
`timescale 1ns/1ps
module test_interrupt_trap_sleep_control;
  import itsc_pkg::*;
  logic I_CLK = 1'b0, I_RST_B = 1'b0, trap_drv, slow, intr_ok;
  logic I_EXT0_PIN, I_EXT1_PIN, I_SW_IRQ, I_STATUS_WR, I_HOST_IN_RD;
  logic I_HOST_OUT_WR, I_SER_IN_RD, I_SER_OUT_WR, I_SER2_IN_RD, I_DBG_RD;
  logic I_SER2_OUT_WR, I_IRETURN, I_BREAKPOINT, I_DBG_TRAP_REQ, I_SLEEP_SET;
  logic I_TRAP_OUT_MODE, I_TRAP_DEBUG_MODE, I_XFER_BUSY, I_INSN_DONE;
  logic I_INSN_INTERRUPTIBLE, I_INSN_TWO_CYCLE, O_TRAP_OUT, O_TRAP_OE;
  logic O_SERVICE_ACK, O_BRANCH, O_ROM_LOW_MAP_FORCE, O_SLEEP_BIT, O_STANDBY;
  itsc_src_t  I_PERIPH_EVENT, I_IRQ_ENABLE, I_STATUS_WDATA, O_IRQ_STATUS;
  itsc_addr_t I_PC_NEXT, I_PC_AFTER_NEXT, O_IRQ_RETURN;
  itsc_code_t O_SOURCE_CODE;
  itsc_vec_t  O_BRANCH_ADDR;
  wire logic  I_TRAP_PIN = O_TRAP_OE ? O_TRAP_OUT : trap_drv;
  int fails = 0, n_compared = 0, cycles = 0;
  localparam logic [6:0] EXP_VEC [13] = '{7'h02, 7'h01, 7'h42, 7'h04,
    7'h10, 7'h14, 7'h18, 7'h20, 7'h24, 7'h2c, 7'h30, 7'h34, 7'h38};
  localparam logic [3:0] EXP_CODE [13] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hc,
    4'hd, 4'he, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};

  itsc_ctrl DUT (.I_CLK, .I_RST_B, .I_PERIPH_EVENT, .I_EXT0_PIN, .I_EXT1_PIN,
    .I_SW_IRQ, .I_IRQ_ENABLE, .I_STATUS_WR, .I_STATUS_WDATA, .I_HOST_IN_RD,
    .I_HOST_OUT_WR, .I_SER_IN_RD, .I_SER_OUT_WR, .I_SER2_IN_RD,
    .I_SER2_OUT_WR, .I_DBG_RD, .I_INSN_DONE, .I_INSN_INTERRUPTIBLE,
    .I_INSN_TWO_CYCLE, .I_PC_NEXT, .I_PC_AFTER_NEXT, .I_IRETURN,
    .I_BREAKPOINT, .I_DBG_TRAP_REQ, .I_TRAP_OUT_MODE, .I_TRAP_DEBUG_MODE,
    .I_TRAP_PIN, .I_SLEEP_SET, .I_XFER_BUSY, .O_TRAP_OUT, .O_TRAP_OE,
    .O_SERVICE_ACK, .O_SOURCE_CODE, .O_IRQ_STATUS, .O_BRANCH,
    .O_BRANCH_ADDR, .O_IRQ_RETURN, .O_ROM_LOW_MAP_FORCE, .O_SLEEP_BIT,
    .O_STANDBY);
  itsc_core_model u_core (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_slow(slow),
    .i_intr_ok(intr_ok), .i_branch(O_BRANCH), .i_branch_addr(O_BRANCH_ADDR),
    .i_standby(O_STANDBY), .o_done(I_INSN_DONE),
    .o_intr(I_INSN_INTERRUPTIBLE), .o_two(I_INSN_TWO_CYCLE),
    .o_pc_next(I_PC_NEXT), .o_pc_after(I_PC_AFTER_NEXT));

  always #4 I_CLK = ~I_CLK;

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // the whole run needs well under 1000 cycles
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      end_sim;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic ev(input int idx);
    @(posedge I_CLK) I_PERIPH_EVENT <= 13'h0001 << idx;
    @(posedge I_CLK) I_PERIPH_EVENT <= '0;
    #1;
  endtask
  // gives up after 60 cycles, so n == 60 means no branch was taken
  task automatic wait_br(output int n);
    n = 0;
    while (O_BRANCH !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
  endtask
  task automatic ret;
    @(posedge I_CLK) I_IRETURN <= 1'b1;
    @(posedge I_CLK) I_IRETURN <= 1'b0;
    #1;
  endtask
  task automatic do_reset;
    @(posedge I_CLK) I_RST_B <= 1'b0;
    tick(3);
    @(posedge I_CLK) I_RST_B <= 1'b1;
    #1;
  endtask
  // serial flags need a later instruction, hence the idle cycles
  task automatic clr_all;
    @(posedge I_CLK) begin
      {I_HOST_IN_RD, I_HOST_OUT_WR, I_SER_IN_RD, I_SER_OUT_WR, I_SER2_IN_RD,
       I_SER2_OUT_WR, I_DBG_RD, I_STATUS_WR} <= 8'hff;
      // write-clear bits are left to the return
      I_STATUS_WDATA <= ~W1C_MASK;
    end
    @(posedge I_CLK) begin
      {I_HOST_IN_RD, I_HOST_OUT_WR, I_SER_IN_RD, I_SER_OUT_WR, I_SER2_IN_RD,
       I_SER2_OUT_WR, I_DBG_RD, I_STATUS_WR} <= 8'h00;
    end
    tick(12);
  endtask

  task automatic t_reset;
    chk({O_SERVICE_ACK, O_TRAP_OE, O_SLEEP_BIT, O_STANDBY}, 16'h0);
    chk(O_IRQ_STATUS, '0);
    $display("t_reset done");
  endtask

  task automatic t_sources;
    int n;
    @(posedge I_CLK) I_IRQ_ENABLE <= '1;
    for (int i = 0; i < 13; i++) begin
      ev(i);
      wait_br(n);
      chk(O_BRANCH_ADDR, EXP_VEC[i]);
      chk(O_SOURCE_CODE, EXP_CODE[i]);
      chk(O_SERVICE_ACK, 1'b1);
      clr_all;
      ret;
      chk({O_SERVICE_ACK, O_SOURCE_CODE}, 16'h0);
      chk(O_IRQ_STATUS, '0);
    end
    $display("t_sources done");
  endtask

  task automatic t_masked;
    int n;
    @(posedge I_CLK) I_IRQ_ENABLE <= '0;
    ev(SRC_TIMER);
    ev(SRC_HIN);
    ev(SRC_DBG);
    ev(SRC_SIN);
    @(posedge I_CLK) I_EXT0_PIN <= 1'b1;
    #1 wait_br(n);
    chk(n, 60);
    chk(O_IRQ_STATUS, 13'h0a16);
    @(posedge I_CLK) begin
      I_STATUS_WR <= 1'b1;
      I_STATUS_WDATA <= 13'h0002;
    end
    @(posedge I_CLK) {I_STATUS_WR, I_HOST_IN_RD} <= 2'b01;
    @(posedge I_CLK) {I_HOST_IN_RD, I_SER_IN_RD} <= 2'b01;
    @(posedge I_CLK) I_SER_IN_RD <= 1'b0;
    #1 chk(O_IRQ_STATUS, 13'h0214);
    tick(4);
    chk(O_IRQ_STATUS, 13'h0014);
    @(posedge I_CLK) I_DBG_RD <= 1'b1;
    @(posedge I_CLK) begin
      {I_DBG_RD, I_STATUS_WR} <= 2'b01;
      I_STATUS_WDATA <= 13'h0010;
    end
    @(posedge I_CLK) {I_STATUS_WR, I_EXT0_PIN} <= 2'b00;
    #1 chk(O_IRQ_STATUS, '0);
    $display("t_masked done");
  endtask

  task automatic t_prio;
    int n;
    @(posedge I_CLK) begin
      {slow, intr_ok} <= 2'b10;
      I_IRQ_ENABLE <= '1;
      I_PERIPH_EVENT <= 13'h0018;
    end
    @(posedge I_CLK) I_PERIPH_EVENT <= '0;
    #1 wait_br(n);
    chk(n, 60);
    @(posedge I_CLK) intr_ok <= 1'b1;
    #1 wait_br(n);
    chk(O_BRANCH_ADDR, 7'h10);
    ret;
    chk(O_IRQ_STATUS, 13'h0008);
    wait_br(n);
    chk(O_BRANCH_ADDR, 7'h04);
    ret;
    chk(O_IRQ_STATUS, '0);
    @(posedge I_CLK) slow <= 1'b0;
    $display("t_prio done");
  endtask

  task automatic t_trap;
    int n;
    @(posedge I_CLK) trap_drv <= 1'b1;
    #1 wait_br(n);
    chk(n > 3 && n < 6, 16'h1);
    chk({O_BRANCH_ADDR, O_SOURCE_CODE, O_SERVICE_ACK}, 16'h08cf);
    @(posedge I_CLK) trap_drv <= 1'b0;
    tick(3);
    @(posedge I_CLK) trap_drv <= 1'b1;
    #1 wait_br(n);
    chk(n, 60);
    ret;
    chk({O_SERVICE_ACK, O_SOURCE_CODE}, 16'h0);
    @(posedge I_CLK) {trap_drv, I_DBG_TRAP_REQ} <= 2'b01;
    @(posedge I_CLK) I_DBG_TRAP_REQ <= 1'b0;
    #1 wait_br(n);
    chk({O_BRANCH_ADDR, O_SERVICE_ACK, O_ROM_LOW_MAP_FORCE}, 16'h0d);
    ret;
    chk(O_ROM_LOW_MAP_FORCE, 1'b0);
    @(posedge I_CLK) I_TRAP_OUT_MODE <= 1'b1;
    do_reset;
    tick(2);
    chk({O_TRAP_OE, O_TRAP_OUT}, 16'h2);
    @(posedge I_CLK) I_BREAKPOINT <= 1'b1;
    @(posedge I_CLK) I_BREAKPOINT <= 1'b0;
    #1 chk(O_TRAP_OUT, 1'b1);
    wait_br(n);
    chk(O_BRANCH_ADDR, 7'h03);
    ret;
    chk(O_TRAP_OUT, 1'b0);
    @(posedge I_CLK) I_TRAP_OUT_MODE <= 1'b0;
    do_reset;
    // slave: pin input requests the debug trap
    @(posedge I_CLK) {I_TRAP_DEBUG_MODE, trap_drv} <= 2'b11;
    #1 wait_br(n);
    chk(O_BRANCH_ADDR, 7'h03);
    ret;
    @(posedge I_CLK) {I_TRAP_DEBUG_MODE, trap_drv} <= 2'b00;
    $display("t_trap done");
  endtask

  task automatic t_sleep;
    @(posedge I_CLK) {I_XFER_BUSY, I_SLEEP_SET} <= 2'b11;
    @(posedge I_CLK) I_SLEEP_SET <= 1'b0;
    #1 chk(O_SLEEP_BIT, 1'b1);
    tick(10); // core keeps issuing instructions after the set
    chk(O_STANDBY, 1'b0);
    @(posedge I_CLK) I_XFER_BUSY <= 1'b0;
    tick(3);
    chk(O_STANDBY, 1'b1);
    @(posedge I_CLK) I_IRQ_ENABLE <= '0;
    ev(SRC_TIMER);
    chk({O_STANDBY, O_SLEEP_BIT}, 16'h0);
    $display("t_sleep done");
  endtask

  initial begin
    {I_EXT0_PIN, I_EXT1_PIN, I_SW_IRQ, I_STATUS_WR, I_HOST_IN_RD, trap_drv,
     I_HOST_OUT_WR, I_SER_IN_RD, I_SER_OUT_WR, I_SER2_IN_RD, I_DBG_RD,
     I_SER2_OUT_WR, I_IRETURN, I_BREAKPOINT, I_DBG_TRAP_REQ, I_SLEEP_SET,
     I_TRAP_OUT_MODE, I_TRAP_DEBUG_MODE, I_XFER_BUSY, slow} = '0;
    intr_ok = 1'b1;
    {I_PERIPH_EVENT, I_IRQ_ENABLE, I_STATUS_WDATA} = '0;
    tick(3);
    @(posedge I_CLK) I_RST_B <= 1'b1;
    tick(1);
    t_reset;
    t_sources;
    t_masked;
    t_prio;
    t_trap;
    t_sleep;
    end_sim;
  end
endmodule
